// *** hw/oqm_modem.sv ***
// O-QPSK modem core: transmit spreading, receive sync, AGC, RSSI, LQI, CCA, antenna select
`timescale 1ns/100ps
module oqm_modem #(
  parameter int ADC_W = oqm_pkg::ADC_W,
  parameter int DAC_W = oqm_pkg::DAC_W
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  // Baseband symbol interface
  input  wire logic              tx_sym_valid,
  output logic                   tx_sym_ready,
  input  wire logic [3:0]        tx_sym,
  input  wire logic              tx_frame_start,
  input  wire logic              tx_retry,
  input  wire logic [2:0]        tx_power_sel,
  input  wire logic              rx_enable,
  output logic                   rx_sym_valid,
  output logic [3:0]             rx_sym,
  output logic                   rx_sfd_found,
  input  wire logic              rx_frame_end,
  output logic [7:0]             rssi,
  output logic [7:0]             lqi,
  output logic                   lqi_valid,
  input  wire logic              cca_req,
  input  wire logic [1:0]        cca_mode,
  input  wire logic [7:0]        ed_threshold,
  output logic                   cca_done,
  output logic                   cca_idle,
  // Radio side
  output logic [DAC_W-1:0]       dac_i,
  output logic [DAC_W-1:0]       dac_q,
  input  wire logic [ADC_W-1:0]  adc_i,
  input  wire logic [ADC_W-1:0]  adc_q,
  output logic [3:0]             rx_gain,
  output logic [3:0]             pa_power,
  output logic                   reg_enable,
  output logic                   antenna_select_out
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0]      tx_chips;     // Chips of symbol in flight
    logic             tx_busy;      // Symbol being sent
    logic [4:0]       chip_idx;     // Current chip
    logic [5:0]       chip_cnt;     // Cycles within a chip
    logic [DAC_W-1:0] dac_i;
    logic [DAC_W-1:0] dac_q;
    logic             antenna;      // Antenna select
    logic [3:0]       pa;           // Power code
    oqm_pkg::oqm_rx_e rx_st;        // Receive phase
    logic [31:0]      rx_shift;     // Sliced received chips
    logic [4:0]       rx_cnt;       // Chips collected
    logic [3:0]       rx_lo;        // Low nibble held for the SFD byte
    logic             rx_half;      // Second nibble pending
    logic [3:0]       gain;
    logic [7:0]       rssi;
    logic [7:0]       lqi;
    logic             lqi_valid;
    logic [7:0]       corr_acc;     // Running correlation average for frame
    logic             rx_sv;
    logic [3:0]       rx_sym;
    logic             sfd;
    logic             cca_done;
    logic             cca_idle;
    logic             carrier;      // Sync seen recently
  } oqm_state_s;
  oqm_state_s st_r;
  oqm_state_s st_nxt;
  // Spreader
  logic [31:0] chips_w;
  oqm_spread u_spread (.sym(tx_sym), .chips(chips_w));
  // Half-sine magnitude, indexed by phase within a one-chip pulse
  function automatic logic [DAC_W-1:0] hsine(input logic [5:0] ph, input logic bit_v);
    logic [DAC_W-2:0] m;
    // Cut to the magnitude width on purpose; the peak step of 60 fits in seven bits
    m = (ph < 6'd16) ? (DAC_W-1)'({ph, 2'b00}) : (DAC_W-1)'({6'd31 - ph, 2'b00});
    hsine = bit_v ? {1'b1, m} : {1'b0, ~m};
  endfunction
  // Best correlation score of received chips over all 16 candidate symbols
  logic [5:0] best_score;
  logic [3:0] best_sym;
  logic [31:0] cand [16];
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_cand
      oqm_spread u_c (.sym(4'(g)), .chips(cand[g]));
    end
  endgenerate
  always_comb begin
    logic [5:0] sc;
    sc = 6'h00;
    best_score = 6'h00;
    best_sym = 4'h0;
    for (int k = 0; k < 16; k++) begin
      sc = 6'($countones(~(cand[k] ^ st_r.rx_shift)));
      if (sc > best_score) begin
        best_score = sc;
        best_sym = 4'(k);
      end
    end
  end
  // Instantaneous amplitude from both samples
  logic [7:0] amp;
  assign amp = 8'({adc_i, 4'h0}) ^ 8'({adc_q, 4'h0}) | 8'(adc_i) ;
  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic ed_busy;
    ed_busy = 1'b0;
    st_nxt = st_r;
    st_nxt.rx_sv = 1'b0;
    st_nxt.sfd = 1'b0;
    st_nxt.cca_done = 1'b0;
    // Transmit: one symbol of 32 chips at 2 Mchip/s gives 62.5 ksym/s, 250 kbit/s
    if (tx_frame_start) begin
      st_nxt.antenna = 1'b0;
    end else if (tx_retry) begin
      st_nxt.antenna = ~st_r.antenna;
    end
    if (tx_power_sel <= 3'(oqm_pkg::PWR_MAX)) begin
      st_nxt.pa = 4'(tx_power_sel);
    end
    if (!st_r.tx_busy) begin
      if (tx_sym_valid) begin
        st_nxt.tx_chips = chips_w;
        st_nxt.tx_busy = 1'b1;
        st_nxt.chip_idx = 5'h00;
        st_nxt.chip_cnt = 6'h00;
      end
    end else if (st_r.chip_cnt == 6'(oqm_pkg::CHIP_CYC - 1)) begin
      st_nxt.chip_cnt = 6'h00;
      st_nxt.chip_idx = st_r.chip_idx + 5'h01;
      if (st_r.chip_idx == 5'h1F) begin
        st_nxt.tx_busy = 1'b0;
      end
    end else begin
      st_nxt.chip_cnt = st_r.chip_cnt + 6'h01;
    end
    // Even chips on I, odd on Q, each a half-sine over one chip time with Q offset one chip
    if (st_r.tx_busy) begin
      if (!st_r.chip_idx[0]) begin
        st_nxt.dac_i = hsine({1'b0, st_r.chip_cnt[5:1]}, st_r.tx_chips[st_r.chip_idx]);
      end else begin
        st_nxt.dac_q = hsine({1'b0, st_r.chip_cnt[5:1]}, st_r.tx_chips[st_r.chip_idx]);
      end
    end else begin
      st_nxt.dac_i = {1'b1, {(DAC_W-1){1'b0}}};
      st_nxt.dac_q = {1'b1, {(DAC_W-1){1'b0}}};
    end
    // Signal strength: first-order average of amplitude
    st_nxt.rssi = 8'((16'(st_r.rssi) * 16'd7 + 16'(amp)) >> 3);
    // Gain loop steers toward mid range
    if (st_r.rssi > oqm_pkg::AGC_HI && st_r.gain != 4'h0) begin
      st_nxt.gain = st_r.gain - 4'h1;
    end else if (st_r.rssi < oqm_pkg::AGC_LO && st_r.gain != 4'hF) begin
      st_nxt.gain = st_r.gain + 4'h1;
    end
    // Receive: sliced chips (sign bits) after digital mixing by sign; offset only rotates phase
    unique case (st_r.rx_st)
      oqm_pkg::OQM_RX_OFF: begin
        if (rx_enable) begin
          st_nxt.rx_st = oqm_pkg::OQM_RX_HUNT;
          st_nxt.lqi_valid = 1'b0;
          st_nxt.corr_acc = 8'h00;
        end
      end
      default: begin
        st_nxt.rx_shift = {st_r.rx_shift[30:0], adc_i[ADC_W-1] ^ adc_q[ADC_W-1]};
        st_nxt.rx_cnt = st_r.rx_cnt + 5'h01;
        if (best_score >= oqm_pkg::SYNC_TH) begin
          st_nxt.carrier = 1'b1;
          if (st_r.rx_st == oqm_pkg::OQM_RX_HUNT) begin
            st_nxt.rx_st = oqm_pkg::OQM_RX_SFD;
            st_nxt.rx_cnt = 5'h00;
          end else if (st_r.rx_cnt == 5'h1F) begin
            if (st_r.rx_st == oqm_pkg::OQM_RX_SFD) begin
              st_nxt.rx_half = ~st_r.rx_half;
              st_nxt.rx_lo = best_sym;
              if (st_r.rx_half && {best_sym, st_r.rx_lo} == oqm_pkg::SFD_BYTE) begin
                st_nxt.rx_st = oqm_pkg::OQM_RX_DATA;
                st_nxt.sfd = 1'b1;
              end
            end else begin
              st_nxt.rx_sv = 1'b1;
              st_nxt.rx_sym = best_sym;
              st_nxt.corr_acc = 8'((16'(st_r.corr_acc) * 16'd3 + 16'({best_score, 2'b00})) >> 2);
            end
          end
        end
        if (rx_frame_end || !rx_enable) begin
          st_nxt.rx_st = oqm_pkg::OQM_RX_OFF;
          st_nxt.carrier = 1'b0;
          if (st_r.rx_st == oqm_pkg::OQM_RX_DATA) begin
            st_nxt.lqi = st_r.corr_acc;
            st_nxt.lqi_valid = 1'b1;
          end
        end
      end
    endcase
    // Channel assessment, one answer per request
    if (cca_req) begin
      ed_busy = st_r.rssi > ed_threshold;
      unique case (cca_mode)
        2'(oqm_pkg::OQM_CCA_ED):   st_nxt.cca_idle = ~ed_busy;
        2'(oqm_pkg::OQM_CCA_CS):   st_nxt.cca_idle = ~st_r.carrier;
        default:                   st_nxt.cca_idle = ~(ed_busy | st_r.carrier);
      endcase
      st_nxt.cca_done = 1'b1;
    end
    if (!rst_b) begin
      st_nxt = '0;
      st_nxt.rx_st = oqm_pkg::OQM_RX_OFF;
      st_nxt.gain = 4'h8;
      st_nxt.dac_i = {1'b1, {(DAC_W-1){1'b0}}};
      st_nxt.dac_q = {1'b1, {(DAC_W-1){1'b0}}};
    end
  end
  // ----------------------------------------------------------------
  // Register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end
  // Outputs
  assign tx_sym_ready       = ~st_r.tx_busy;
  assign dac_i              = st_r.dac_i;
  assign dac_q              = st_r.dac_q;
  assign rx_gain            = st_r.gain;
  assign pa_power           = st_r.pa;
  assign reg_enable         = st_r.tx_busy | (st_r.rx_st != oqm_pkg::OQM_RX_OFF);
  assign antenna_select_out = st_r.antenna;
  assign rx_sym_valid       = st_r.rx_sv;
  assign rx_sym             = st_r.rx_sym;
  assign rx_sfd_found       = st_r.sfd;
  assign rssi               = st_r.rssi;
  assign lqi                = st_r.lqi;
  assign lqi_valid          = st_r.lqi_valid;
  assign cca_done           = st_r.cca_done;
  assign cca_idle           = st_r.cca_idle;
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_ant_first;
    @(posedge clk) disable iff (!rst_b) tx_frame_start |=> !antenna_select_out;
  endproperty
  a_ant_first: assert property (p_ant_first) else $error("antenna not cleared on new frame");
  property p_ant_toggle;
    @(posedge clk) disable iff (!rst_b) (tx_retry && !tx_frame_start) |=>
      antenna_select_out != $past(antenna_select_out);
  endproperty
  a_ant_toggle: assert property (p_ant_toggle) else $error("antenna did not toggle on retry");
  property p_cca_one;
    @(posedge clk) disable iff (!rst_b) cca_req |=> cca_done;
  endproperty
  a_cca_one: assert property (p_cca_one) else $error("no assessment answer");
  property p_pa_range;
    @(posedge clk) disable iff (!rst_b) pa_power <= oqm_pkg::PWR_MAX;
  endproperty
  a_pa_range: assert property (p_pa_range) else $error("power code out of range");
  sequence s_sym_take;
    tx_sym_valid && tx_sym_ready;
  endsequence
  property p_sym_len;
    @(posedge clk) disable iff (!rst_b) s_sym_take |=> !tx_sym_ready [*8];
  endproperty
  a_sym_len: assert property (p_sym_len) else $error("symbol ended early");
  property p_reg_tx;
    @(posedge clk) disable iff (!rst_b) !tx_sym_ready |-> reg_enable;
  endproperty
  a_reg_tx: assert property (p_reg_tx) else $error("regulators off while sending");
  property p_lqi_hold;
    @(posedge clk) disable iff (!rst_b) (lqi_valid && !rx_enable) |=> $stable(lqi);
  endproperty
  a_lqi_hold: assert property (p_lqi_hold) else $error("link quality changed after frame");
  property p_gain_step;
    @(posedge clk) disable iff (!rst_b) ##1 (rx_gain == $past(rx_gain) || rx_gain == $past(rx_gain) + 4'h1
      || rx_gain == $past(rx_gain) - 4'h1);
  endproperty
  a_gain_step: assert property (p_gain_step) else $error("gain jumped");
endmodule

// *** common/oqm_pkg.sv ***
// Package of constants and types for the O-QPSK modem with antenna diversity
// What this block does
// - Each 4-bit symbol becomes its own 32-chip sequence
// - O-QPSK half-sine shaping gives separate I and Q
// - Payload runs at 250 kbit/s in 2450 MHz band
// - I and Q streams go to two converter channels
// - Receive input is flash converter samples
// - Gain control holds received amplitude near optimum
// - Digital IF mixing by sign tolerates offset
// - Correlation finds preamble and start-of-frame delimiter
// - Digital signal strength feeds energy detection
// - Correlation magnitude gives quality metric for link
// - Three channel assessment modes: energy, carrier, both
// - Amplifier power takes one of six settings
// - Antenna select high on odd retries only
// - Retry after missing acknowledge uses other antenna
// - Regulators powered only while radio needs them
// - Link quality held readable after frame ends
package oqm_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ        = 125;                 // System clock rate
  localparam int CHIP_RATE_KHZ  = 2000;                // Chip rate in kchip/s
  localparam int CHIP_CYC       = (CLK_MHZ * 1000) / CHIP_RATE_KHZ; // Cycles per chip, rounded down
  localparam int CHIPS_PER_SYM  = 32;                  // Chips in one symbol
  localparam int SHAPE_STEPS    = 16;                  // Half-sine table points on the rising half of a pulse
  // ----------------------------------------------------------------
  // Receive and transmit thresholds and widths
  // ----------------------------------------------------------------
  localparam int ADC_W          = 4;                   // Flash converter sample width
  localparam int DAC_W          = 8;                   // Transmit converter word width
  localparam int GAIN_W         = 4;                   // Gain code width
  localparam logic [7:0] AGC_HI = 8'hC0;               // Level above which gain drops
  localparam logic [7:0] AGC_LO = 8'h40;               // Level below which gain rises
  localparam logic [5:0] SYNC_TH = 6'h1C;              // Correlation hits to accept a symbol
  localparam logic [3:0] PWR_MAX = 4'h5;               // Highest of six power codes
  // Channel assessment modes
  typedef enum logic [1:0] {
    OQM_CCA_ED = 2'h1,
    OQM_CCA_CS = 2'h2,
    OQM_CCA_BOTH = 2'h3
  } oqm_cca_e;
  // Receive state machine
  typedef enum logic [3:0] {
    OQM_RX_OFF  = 4'h1,
    OQM_RX_HUNT = 4'h2,
    OQM_RX_SFD  = 4'h4,
    OQM_RX_DATA = 4'h8
  } oqm_rx_e;
  // Base chip sequence for symbol 0; others are cyclic shifts and conjugates
  localparam logic [31:0] PN0 = 32'hD9C3522E;
  localparam logic [7:0] SFD_BYTE = 8'hA7;             // Start-of-frame delimiter
endpackage

// *** hw/oqm_spread.sv ***
// Symbol to chip sequence spreader
`timescale 1ns/100ps
module oqm_spread (
  input  wire logic [3:0]  sym,
  output logic      [31:0] chips
);
  // ----------------------------------------------------------------
  // Table lookup: shift base sequence by 4 chips per symbol step, odd
  // chips inverted for the upper half of symbol values
  // ----------------------------------------------------------------
  logic [31:0] rot;
  always_comb begin
    rot   = oqm_pkg::PN0;
    rot   = (rot >> {sym[2:0], 2'b00}) | (rot << (6'd32 - {1'b0, sym[2:0], 2'b00}));
    chips = sym[3] ? (rot ^ 32'hAAAAAAAA) : rot;
  end
endmodule

// *** test/oqm_radio_model.sv ***
// Behavioural radio front end: converters, gain stages and regulators
`timescale 1ns/100ps
module oqm_radio_model #(
  parameter int ADC_W = 4,
  parameter int DAC_W = 8
) (
  input  wire logic              clk,
  input  wire logic [DAC_W-1:0]  dac_i,
  input  wire logic [DAC_W-1:0]  dac_q,
  input  wire logic [3:0]        rx_gain,
  input  wire logic              reg_enable,
  output logic      [ADC_W-1:0]  adc_i,
  output logic      [ADC_W-1:0]  adc_q
);
  // ----------------------------------------------------------------
  // Sample path
  // ----------------------------------------------------------------
  logic [ADC_W-1:0] wobble_r = '0;  // Changes every cycle so an unpowered ADC never looks steady

  // Loop transmit back into receive; gain code bits 0 and 1 flip the lowest bit of I and Q
  // Unpowered radio gives a moving pattern, not the last value
  always @(posedge clk) begin
    wobble_r <= wobble_r + 1'b1;
    if (reg_enable) begin
      adc_i <= dac_i[DAC_W-1 -: ADC_W] ^ {{(ADC_W-1){1'b0}}, rx_gain[0]};
      adc_q <= dac_q[DAC_W-1 -: ADC_W] ^ {{(ADC_W-1){1'b0}}, rx_gain[1]};
    end else begin
      adc_i <= wobble_r;
      adc_q <= ~wobble_r;
    end
  end
endmodule

// *** test/oqpsk_modem_antenna_diversity_tb.sv ***
// Self-checking bench for the O-QPSK modem with antenna diversity
`timescale 1ns/100ps
module oqpsk_modem_antenna_diversity_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic tx_sym_valid = 1'b0, tx_frame_start = 1'b0, tx_retry = 1'b0;
  logic rx_enable = 1'b0, rx_frame_end = 1'b0, cca_req = 1'b0;
  logic [3:0] tx_sym = 4'h0;
  logic [2:0] tx_power_sel = 3'h0;
  logic [1:0] cca_mode = 2'h1;
  logic [7:0] ed_threshold = 8'hFF;
  logic tx_sym_ready, rx_sym_valid, rx_sfd_found, lqi_valid, cca_done, cca_idle, reg_enable, antenna_select_out;
  logic [3:0] rx_sym, rx_gain, pa_power, adc_i, adc_q;
  logic [7:0] rssi, lqi, dac_i, dac_q;
  int mismatches = 0;
  int n_tests = 0;

  always #4 clk = ~clk;  // 125 MHz

  oqm_modem dut (.clk(clk), .rst_b(rst_b), .tx_sym_valid(tx_sym_valid), .tx_sym_ready(tx_sym_ready),
    .tx_sym(tx_sym), .tx_frame_start(tx_frame_start), .tx_retry(tx_retry), .tx_power_sel(tx_power_sel),
    .rx_enable(rx_enable), .rx_sym_valid(rx_sym_valid), .rx_sym(rx_sym), .rx_sfd_found(rx_sfd_found),
    .rx_frame_end(rx_frame_end), .rssi(rssi), .lqi(lqi), .lqi_valid(lqi_valid), .cca_req(cca_req),
    .cca_mode(cca_mode), .ed_threshold(ed_threshold), .cca_done(cca_done), .cca_idle(cca_idle),
    .dac_i(dac_i), .dac_q(dac_q), .adc_i(adc_i), .adc_q(adc_q), .rx_gain(rx_gain), .pa_power(pa_power),
    .reg_enable(reg_enable), .antenna_select_out(antenna_select_out));
  oqm_radio_model u_radio (.clk(clk), .dac_i(dac_i), .dac_q(dac_q), .rx_gain(rx_gain),
    .reg_enable(reg_enable), .adc_i(adc_i), .adc_q(adc_q));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Compare and count; report at once on a difference
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One antenna event, then look at the select line after it lands
  task automatic ant_step(input logic fs, input logic rt, input logic exp);
    @(posedge clk);
    tx_frame_start <= fs;
    tx_retry <= rt;
    @(posedge clk);
    tx_frame_start <= 1'b0;
    tx_retry <= 1'b0;
    #1 chk("antenna_select_out", antenna_select_out, exp);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Levels while reset is held; gain starts moving on the first free edge
  task automatic t_reset;
    chk("antenna_select_out", antenna_select_out, 1'b0);
    chk("dac_i", dac_i, 8'h80);
    chk("dac_q", dac_q, 8'h80);
    chk("tx_sym_ready", tx_sym_ready, 1'b1);
    chk("rx_gain", rx_gain, 4'h8);
    chk("lqi_valid", lqi_valid, 1'b0);
    chk("lqi", lqi, 8'h00);
    chk("rssi", rssi, 8'h00);
    chk("reg_enable", reg_enable, 1'b0);
    chk("pa_power", pa_power, 4'h0);
    chk("cca_done", cca_done, 1'b0);
    chk("rx_sfd_found", rx_sfd_found, 1'b0);
    chk("rx_sym_valid", rx_sym_valid, 1'b0);
    chk("rx_sym", rx_sym, 4'h0);
  endtask

  // New frame clears, retries toggle, frame start wins over retry
  task automatic t_antenna;
    ant_step(1'b1, 1'b0, 1'b0);
    ant_step(1'b0, 1'b1, 1'b1);
    ant_step(1'b0, 1'b1, 1'b0);
    ant_step(1'b0, 1'b1, 1'b1);
    ant_step(1'b1, 1'b1, 1'b0);
  endtask

  // Every power code; codes past the six legal ones keep the last
  task automatic t_power;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      tx_power_sel <= 3'(i);
      @(posedge clk);
      #1 chk("pa_power", pa_power, (i < 6) ? i : 5);
    end
  endtask

  // Each mode answers with one done pulse; pass 0 is energy mode against 0xFF,
  // which no level can beat; later passes use threshold 0 on the noisy idle radio,
  // so energy reads busy and only carrier sense (no sync yet) reads idle
  task automatic t_cca;
    for (int m = 0; m < 5; m++) begin
      @(posedge clk);
      cca_req <= 1'b1;
      cca_mode <= (m == 0) ? 2'h1 : 2'(m);
      ed_threshold <= (m == 0) ? 8'hFF : 8'h00;
      @(posedge clk);
      cca_req <= 1'b0;
      #1 chk("cca_done", cca_done, 1'b1);
      chk("cca_idle", cca_idle, (m == 0 || m == 2));
      @(posedge clk);
      #1 chk("cca_done", cca_done, 1'b0);
    end
  endtask

  // Back-to-back symbols; each holds the path for 32 chip times
  task automatic t_tx;
    int cnt;
    int moves;
    logic [7:0] last;
    logic [3:0] lvl;  // Above and below midscale seen, I then Q
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      tx_sym_valid <= 1'b1;
      tx_sym <= s ? 4'hF : 4'h0;
      @(posedge clk);
      tx_sym_valid <= 1'b0;
      #1 chk("tx_sym_ready", tx_sym_ready, 1'b0);
      chk("reg_enable", reg_enable, 1'b1);
      cnt = 0;
      moves = 0;
      last = dac_i;
      lvl = 4'h0;
      while (tx_sym_ready !== 1'b1 && cnt < 3000) begin
        @(posedge clk);
        #1 cnt++;
        if (dac_i !== last) moves++;
        last = dac_i;
        lvl = lvl | {dac_i > 8'h80, dac_i < 8'h80, dac_q > 8'h80, dac_q < 8'h80};
      end
      chk("symbol_cycles_ok", (cnt >= 32 * oqm_pkg::CHIP_CYC - 2) &&
        (cnt <= 32 * oqm_pkg::CHIP_CYC + 2), 1'b1);
      chk("dac_i_moves", moves > 0, 1'b1);
      // Both test symbols hold ones and zeros on each branch, so both polarities show
      chk("dac_levels", lvl, 4'hF);
    end
  endtask

  // Sixteen distinct sequences, symbol 0 on the base pattern; the spreader is
  // probed inside the modem while no symbol is offered
  task automatic t_spread;
    logic [31:0] seqs [16];
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      tx_sym <= 4'(i);
      #1 seqs[i] = dut.chips_w;
    end
    chk("chips_sym0", seqs[0], oqm_pkg::PN0);
    for (int i = 0; i < 16; i++)
      for (int j = i + 1; j < 16; j++)
        chk("chips_distinct", seqs[i] != seqs[j], 1'b1);
  endtask

  // Receive a quiet looped-back channel: no preamble so no sync, weak level so
  // gain climbs to the top; end the frame, re-enable: quality flag stays clear
  task automatic t_rx;
    int hits;
    hits = 0;
    @(posedge clk);
    rx_enable <= 1'b1;
    repeat (400) begin
      @(posedge clk);
      #1 if (rx_sfd_found || rx_sym_valid) hits++;
    end
    chk("rx_sync_hits", hits, 0);
    chk("rx_gain", rx_gain, 4'hF);
    chk("rssi_low", rssi < oqm_pkg::AGC_LO, 1'b1);
    chk("reg_enable", reg_enable, 1'b1);
    @(posedge clk);
    rx_frame_end <= 1'b1;
    @(posedge clk);
    rx_frame_end <= 1'b0;
    rx_enable <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("reg_enable", reg_enable, 1'b0);
    chk("lqi_valid", lqi_valid, 1'b0);
    @(posedge clk);
    rx_enable <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("lqi_valid", lqi_valid, 1'b0);
    @(posedge clk);
    rx_enable <= 1'b0;
  endtask

  // Reset in mid-run with the antenna switched over: everything returns to rest
  task automatic t_midreset;
    @(posedge clk);
    tx_retry <= 1'b1;
    @(posedge clk);
    tx_retry <= 1'b0;
    #1 chk("antenna_select_out", antenna_select_out, 1'b1);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    #1 t_reset();
    @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1 chk("antenna_select_out", antenna_select_out, 1'b0);
    chk("tx_sym_ready", tx_sym_ready, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic end_of_test;
    if (mismatches == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Whole run is near 4450 cycles; over four times that means a hang
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_of_test();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    // Still in reset at this edge: the release lands on the next one
    #1 t_reset();
    t_spread();
    t_antenna();
    t_power();
    t_cca();
    t_tx();
    t_rx();
    t_midreset();
    end_of_test();
  end
endmodule
